/* File: pkg/bec_pkg.sv */
package bec_pkg;
   // register indices; the byte address is four times the index
   localparam logic [9:0] IDX_CTRL = 10'h100;
   localparam logic [9:0] IDX_FMT = 10'h101;
   localparam logic [9:0] IDX_ROP = 10'h102;
   localparam logic [9:0] IDX_OP = 10'h103;
   localparam logic [9:0] IDX_OFS_LO = 10'h10C;
   localparam logic [9:0] IDX_OFS_HI = 10'h10D;
   localparam logic [9:0] IDX_IRQ_STAT = 10'h120;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h121;
   localparam int unsigned CTRL_ACTIVE = 7;
   localparam int unsigned CTRL_NOT_EMPTY = 6;
   localparam int unsigned CTRL_HALF = 5;
   localparam int unsigned CTRL_FULL = 4;
   localparam int unsigned CTRL_DST_LIN = 1;
   localparam int unsigned CTRL_SRC_LIN = 0;
   localparam int unsigned FMT_BPP16 = 0;
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_FULL = 1;
   localparam int unsigned IRQ_REFUSED = 2;
   localparam int unsigned IRQ_W = 3;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [23:0] RD_PAD = 24'h000000;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned FIFO_HALF_MARK = 7;
   localparam int unsigned FIFO_FULL_MARK = 15;
   localparam int unsigned ADDR_W = 21;
   localparam int unsigned PIX_W = 16;
   localparam int unsigned CNT_W = 10;
   localparam int unsigned OFS_W = 16;
   localparam int unsigned ROP_W = 4;
   typedef enum logic [3:0] {
      OP_WRITE = 4'h0, OP_READ = 4'h1, OP_MOVE_POS = 4'h2, OP_MOVE_NEG = 4'h3,
      OP_WRITE_TR = 4'h4, OP_MOVE_TR = 4'h5, OP_FILL_PAT = 4'h6, OP_FILL_PAT_TR = 4'h7,
      OP_EXPAND = 4'h8, OP_EXPAND_TR = 4'h9, OP_MOVE_EXP = 4'hA, OP_MOVE_EXP_TR = 4'hB,
      OP_SOLID = 4'hC
   } bec_op_type;
   typedef struct packed {
      logic reserved;
      logic read;
      logic move;
      logic negative;
      logic transparent;
      logic pattern;
      logic expand;
      logic solid;
   } bec_class_type;
   typedef struct packed {
      logic [PIX_W-1:0] src;
      logic [PIX_W-1:0] pat;
      logic [PIX_W-1:0] dst;
   } bec_pix_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_DONE = 2'b11, ST_STEP = 2'b10
   } bec_state_type;
endpackage

/* File: rtl/bec_fifo_level.sv */
`timescale 1ns/1ps
module bec_fifo_level #(
   parameter int unsigned DEPTH = bec_pkg::FIFO_DEPTH,
   parameter int unsigned HALF_MARK = bec_pkg::FIFO_HALF_MARK,
   parameter int unsigned FULL_MARK = bec_pkg::FIFO_FULL_MARK,
   parameter int unsigned LW = $clog2(DEPTH + 1)
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // word moves of the transfer fifo
   input wire logic push_i,
   input wire logic pop_i,
   // occupancy and flags
   output logic [LW-1:0] level_o,
   output logic not_empty_o,
   output logic half_o,
   output logic full_o
);
   if (HALF_MARK < 1 || FULL_MARK <= HALF_MARK || FULL_MARK > DEPTH) begin : g_chk
      $error("bec_fifo_level: marks do not fit the depth");
   end
   logic [LW-1:0] level_nxt;
   logic do_push;
   logic do_pop;
   // a push into a full store or a pop from an empty one is dropped
   assign do_push = push_i && (level_o != LW'(DEPTH));
   assign do_pop = pop_i && (level_o != '0);
   always_comb begin
      level_nxt = level_o;
      if (do_push && !do_pop) begin
         level_nxt = level_o + 1'b1;
      end else if (do_pop && !do_push) begin
         level_nxt = level_o - 1'b1;
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_o <= '0;
         not_empty_o <= 1'b0;
         half_o <= 1'b0;
         full_o <= 1'b0;
      end else begin
         level_o <= level_nxt;
         not_empty_o <= level_nxt != '0;
         half_o <= level_nxt >= LW'(HALF_MARK);
         full_o <= level_nxt >= LW'(FULL_MARK);
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   not_empty_flag_a: assert property (not_empty_o == (level_o != '0))
      else $error("not-empty flag disagrees with level");
   half_flag_a: assert property (half_o == (level_o >= LW'(HALF_MARK)))
      else $error("half-full flag disagrees with level");
   full_flag_a: assert property (full_o == (level_o >= LW'(FULL_MARK)))
      else $error("full flag disagrees with level");
   level_code_a: assert property (full_o |-> half_o && not_empty_o)
      else $error("illegal flag combination");
   level_step_a: assert property (push_i && !pop_i && !full_o |=> level_o == $past(level_o) + 1'b1)
      else $error("push did not raise level");
   fill_up_c: cover property (full_o);
endmodule

/* File: rtl/bec_rop.sv */
`timescale 1ns/1ps
module bec_rop #(
   parameter int unsigned W = bec_pkg::PIX_W
) (
   // truth-table code
   input wire logic [3:0] code_i,
   // source (or pattern) and destination pixels
   input wire logic [W-1:0] s_i,
   input wire logic [W-1:0] d_i,
   // result
   output logic [W-1:0] y_o
);
   if (W < 1) begin : g_chk
      $error("bec_rop: width must be at least one");
   end
   // each result bit is the code bit picked by the pair {s, d}
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign y_o[i] = code_i[{s_i[i], d_i[i]}];
   end
endmodule

/* File: rtl/bec_top.sv */
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
// What this block does
// - not-empty flag shows fifo holds words
// - three flags encode fifo occupancy ranges
// - half-full flag set at seven or more words
// - full flag set when one entry or none free
// - destination linear select: contiguous or rectangle
// - source linear select: contiguous or rectangle
// - rectangles step lines by address offset
// - raster code is a source/destination truth table
// - low raster bits give expansion start bit
// - decode operation codes zero to six
// - decode codes seven to twelve, rest reserved
module bec_top
   import bec_pkg::*;
#(
   parameter int unsigned AW = bec_pkg::ADDR_W,
   parameter int unsigned CW = bec_pkg::CNT_W
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // transfer geometry from the address registers
   input wire logic [AW-1:0] src_start_i,
   input wire logic [AW-1:0] dst_start_i,
   input wire logic [CW-1:0] line_pixels_i,
   input wire logic [CW-1:0] line_count_i,
   input wire logic mem_rdy_i,
   // transfer fifo word moves
   input wire logic fifo_push_i,
   input wire logic fifo_pop_i,
   // pixel datapath
   input wire logic pix_valid_i,
   input wire bec_pkg::bec_pix_type pix_i,
   output logic [PIX_W-1:0] rop_pix_o,
   output logic rop_valid_o,
   // engine state
   output logic busy_o,
   output bec_pkg::bec_class_type op_class_o,
   output logic bpp16_o,
   output logic [2:0] expand_bit_o,
   output logic addr_valid_o,
   output logic [AW-1:0] src_addr_o,
   output logic [AW-1:0] dst_addr_o,
   // interrupt
   output logic irq_o
);
   import bec_pkg::*;
   if (AW < 2 || AW < OFS_W || CW < 1) begin : g_chk
      $error("bec_top: address or count width too small");
   end

   function automatic bec_class_type decode(input logic [3:0] op);
      bec_class_type c;
      c = '0;
      case (op)
         OP_WRITE: c.solid = 1'b0;
         OP_READ: c.read = 1'b1;
         OP_MOVE_POS: c.move = 1'b1;
         OP_MOVE_NEG: begin
            c.move = 1'b1;
            c.negative = 1'b1;
         end
         OP_WRITE_TR: c.transparent = 1'b1;
         OP_MOVE_TR: begin
            c.move = 1'b1;
            c.transparent = 1'b1;
         end
         OP_FILL_PAT: c.pattern = 1'b1;
         OP_FILL_PAT_TR: begin
            c.pattern = 1'b1;
            c.transparent = 1'b1;
         end
         OP_EXPAND: c.expand = 1'b1;
         OP_EXPAND_TR: begin
            c.expand = 1'b1;
            c.transparent = 1'b1;
         end
         OP_MOVE_EXP: begin
            c.move = 1'b1;
            c.expand = 1'b1;
         end
         OP_MOVE_EXP_TR: begin
            c.move = 1'b1;
            c.expand = 1'b1;
            c.transparent = 1'b1;
         end
         OP_SOLID: c.solid = 1'b1;
         default: c.reserved = 1'b1;
      endcase
      return c;
   endfunction

   bec_state_type state_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic src_lin_r;
   logic dst_lin_r;
   logic bpp16_r;
   logic [3:0] rop_r;
   logic [3:0] op_r;
   logic [OFS_W-1:0] ofs_r;
   logic [IRQ_W-1:0] stat_r;
   logic [IRQ_W-1:0] stat_nxt;
   logic [IRQ_W-1:0] mask_r;
   logic irq_r;
   logic busy_r;
   logic full_q;
   logic [AW-1:0] src_cur_r;
   logic [AW-1:0] dst_cur_r;
   logic [AW-1:0] src_line_r;
   logic [AW-1:0] dst_line_r;
   logic [CW-1:0] pix_cnt_r;
   logic [CW-1:0] line_cnt_r;
   logic [AW-1:0] src_addr_r;
   logic [AW-1:0] dst_addr_r;
   logic addr_valid_r;
   logic [PIX_W-1:0] rop_pix_r;
   logic rop_valid_r;
   bec_class_type cls_r;
   bec_class_type cls_now;
   logic fifo_ne;
   logic fifo_hf;
   logic fifo_full;
   logic [PIX_W-1:0] rop_y;
   logic [7:0] rd_byte;
   logic [7:0] ctrl_rd;

   // bus request decode
   logic req;
   logic wr;
   logic [9:0] idx;
   logic start_hit;
   logic start_ok;
   logic refused;
   logic pix_last;
   logic line_last;
   logic [AW-1:0] step;
   logic [AW-1:0] ofs_ext;
   assign req = wb_cyc_i && wb_stb_i && !ack_r;
   // a write lands at the edge where the master sees ack, not at the taking edge
   assign wr = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
   assign idx = wb_adr_i[11:2];
   assign cls_now = decode(op_r);
   assign start_hit = wr && (idx == IDX_CTRL) && wb_dat_i[CTRL_ACTIVE] && (state_r == ST_IDLE);
   assign start_ok = start_hit && !cls_now.reserved;
   assign refused = start_hit && cls_now.reserved;
   assign pix_last = pix_cnt_r == CW'(line_pixels_i - 1'b1);
   assign line_last = line_cnt_r == CW'(line_count_i - 1'b1);
   assign step = bpp16_r ? AW'(2) : AW'(1);
   assign ofs_ext = AW'(ofs_r);

   function automatic logic [AW-1:0] adv(input logic [AW-1:0] a, input logic [AW-1:0] d,
                                          input logic neg);
      return neg ? AW'(a - d) : AW'(a + d);
   endfunction

   bec_fifo_level #(
      .DEPTH(FIFO_DEPTH),
      .HALF_MARK(FIFO_HALF_MARK),
      .FULL_MARK(FIFO_FULL_MARK)
   ) u_level (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .push_i(fifo_push_i),
      .pop_i(fifo_pop_i),
      .level_o(),
      .not_empty_o(fifo_ne),
      .half_o(fifo_hf),
      .full_o(fifo_full)
   );

   // pattern pixels replace source pixels during pattern fill
   bec_rop #(
      .W(PIX_W)
   ) u_rop (
      .code_i(rop_r),
      .s_i(cls_r.pattern ? pix_i.pat : pix_i.src),
      .d_i(pix_i.dst),
      .y_o(rop_y)
   );

   // register read mux
   assign ctrl_rd = {busy_r, fifo_ne, fifo_hf, fifo_full, 2'b00, dst_lin_r, src_lin_r};
   always_comb begin
      rd_byte = RESET_BYTE;
      if (idx == IDX_CTRL) begin
         rd_byte = ctrl_rd;
      end else if (idx == IDX_FMT) begin
         rd_byte = {7'h00, bpp16_r};
      end else if (idx == IDX_ROP) begin
         rd_byte = {4'h0, rop_r};
      end else if (idx == IDX_OP) begin
         rd_byte = {4'h0, op_r};
      end else if (idx == IDX_OFS_LO) begin
         rd_byte = ofs_r[7:0];
      end else if (idx == IDX_OFS_HI) begin
         rd_byte = ofs_r[15:8];
      end else if (idx == IDX_IRQ_STAT) begin
         rd_byte = {5'h00, stat_r};
      end else if (idx == IDX_IRQ_MASK) begin
         rd_byte = {5'h00, mask_r};
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_r <= 1'b0;
         dat_r <= '0;
      end else begin
         ack_r <= req;
         if (req) begin
            dat_r <= wb_we_i ? '0 : {RD_PAD, rd_byte};
         end
      end
   end

   // software-written configuration; reserved format bit is not stored
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src_lin_r <= 1'b0;
         dst_lin_r <= 1'b0;
         bpp16_r <= 1'b0;
         rop_r <= '0;
         op_r <= '0;
         ofs_r <= '0;
         mask_r <= '0;
      end else if (wr) begin
         if (idx == IDX_CTRL) begin
            src_lin_r <= wb_dat_i[CTRL_SRC_LIN];
            dst_lin_r <= wb_dat_i[CTRL_DST_LIN];
         end else if (idx == IDX_FMT) begin
            bpp16_r <= wb_dat_i[FMT_BPP16];
         end else if (idx == IDX_ROP) begin
            rop_r <= wb_dat_i[3:0];
         end else if (idx == IDX_OP) begin
            op_r <= wb_dat_i[3:0];
         end else if (idx == IDX_OFS_LO) begin
            ofs_r[7:0] <= wb_dat_i[7:0];
         end else if (idx == IDX_OFS_HI) begin
            ofs_r[15:8] <= wb_dat_i[7:0];
         end else if (idx == IDX_IRQ_MASK) begin
            mask_r <= wb_dat_i[IRQ_W-1:0];
         end
      end
   end

   // engine sequencer
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
         busy_r <= 1'b0;
      end else begin
         busy_r <= start_ok || (busy_r && state_r != ST_DONE);
         case (state_r)
            ST_IDLE: begin
               if (start_ok) begin
                  state_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (mem_rdy_i && pix_last) begin
                  state_r <= line_last ? ST_DONE : ST_STEP;
               end
            end
            ST_STEP: state_r <= ST_RUN;
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // address walk: pixels along a line, then linear or offset line step
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src_cur_r <= '0;
         dst_cur_r <= '0;
         src_line_r <= '0;
         dst_line_r <= '0;
         pix_cnt_r <= '0;
         line_cnt_r <= '0;
      end else if (start_ok) begin
         src_cur_r <= src_start_i;
         dst_cur_r <= dst_start_i;
         src_line_r <= src_start_i;
         dst_line_r <= dst_start_i;
         pix_cnt_r <= '0;
         line_cnt_r <= '0;
      end else if (state_r == ST_RUN && mem_rdy_i && !pix_last) begin
         pix_cnt_r <= pix_cnt_r + 1'b1;
         src_cur_r <= adv(src_cur_r, step, cls_r.negative);
         dst_cur_r <= adv(dst_cur_r, step, cls_r.negative);
      end else if (state_r == ST_STEP) begin
         pix_cnt_r <= '0;
         line_cnt_r <= line_cnt_r + 1'b1;
         if (src_lin_r) begin
            src_cur_r <= adv(src_cur_r, step, cls_r.negative);
         end else begin
            src_line_r <= adv(src_line_r, ofs_ext, cls_r.negative);
            src_cur_r <= adv(src_line_r, ofs_ext, cls_r.negative);
         end
         if (dst_lin_r) begin
            dst_cur_r <= adv(dst_cur_r, step, cls_r.negative);
         end else begin
            dst_line_r <= adv(dst_line_r, ofs_ext, cls_r.negative);
            dst_cur_r <= adv(dst_line_r, ofs_ext, cls_r.negative);
         end
      end
   end

   // registered outputs of the walk and the pixel path
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_valid_r <= 1'b0;
         src_addr_r <= '0;
         dst_addr_r <= '0;
         rop_pix_r <= '0;
         rop_valid_r <= 1'b0;
         cls_r <= '0;
      end else begin
         cls_r <= cls_now;
         addr_valid_r <= (state_r == ST_RUN) && mem_rdy_i;
         if (state_r == ST_RUN && mem_rdy_i) begin
            src_addr_r <= src_cur_r;
            dst_addr_r <= dst_cur_r;
         end
         rop_valid_r <= pix_valid_i;
         if (pix_valid_i) begin
            rop_pix_r <= rop_y;
         end
      end
   end

   // interrupt status: set wins over a same-cycle write-one clear
   always_comb begin
      stat_nxt = stat_r;
      if (wr && idx == IDX_IRQ_STAT) begin
         stat_nxt = stat_r & ~wb_dat_i[IRQ_W-1:0];
      end
      stat_nxt[IRQ_DONE] = stat_nxt[IRQ_DONE] | (state_r == ST_DONE);
      stat_nxt[IRQ_FULL] = stat_nxt[IRQ_FULL] | (fifo_full && !full_q);
      stat_nxt[IRQ_REFUSED] = stat_nxt[IRQ_REFUSED] | refused;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_r <= '0;
         full_q <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         full_q <= fifo_full;
         irq_r <= |(stat_nxt & mask_r);
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign busy_o = busy_r;
   assign op_class_o = cls_r;
   assign bpp16_o = bpp16_r;
   assign expand_bit_o = rop_r[2:0];
   assign addr_valid_o = addr_valid_r;
   assign src_addr_o = src_addr_r;
   assign dst_addr_o = dst_addr_r;
   assign rop_pix_o = rop_pix_r;
   assign rop_valid_o = rop_valid_r;
   assign irq_o = irq_r;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   start_busy_a: assert property (start_ok |=> busy_o && state_r == ST_RUN)
      else $error("start did not make the engine busy");
   busy_read_a: assert property (req && !wb_we_i && idx == IDX_CTRL |=> wb_dat_o[CTRL_ACTIVE] == $past(busy_r))
      else $error("active bit does not show busy");
   reserved_op_a: assert property (refused |=> !busy_o ##1 stat_r[IRQ_REFUSED])
      else $error("reserved operation was started");
   rop_const_a: assert property (pix_valid_i && rop_r == 4'h0 |=> rop_pix_o == '0)
      else $error("zero code gave nonzero pixel");
   rop_src_a: assert property (pix_valid_i && rop_r == 4'hC && !cls_r.pattern |=> rop_pix_o == $past(pix_i.src))
      else $error("copy code did not pass source");
   rop_pat_a: assert property (pix_valid_i && rop_r == 4'hC && cls_r.pattern |=> rop_pix_o == $past(pix_i.pat))
      else $error("pattern fill did not use pattern");
   line_ofs_a: assert property (state_r == ST_STEP && !src_lin_r && !cls_r.negative |=> src_cur_r == AW'($past(src_line_r) + $past(ofs_ext)))
      else $error("source line step ignored offset");
   dst_lin_a: assert property (state_r == ST_STEP && dst_lin_r && !cls_r.negative |=> dst_cur_r == AW'($past(dst_cur_r) + $past(step)))
      else $error("linear destination not contiguous");
   src_lin_a: assert property (state_r == ST_STEP && src_lin_r && !cls_r.negative |=> src_cur_r == AW'($past(src_cur_r) + $past(step)))
      else $error("linear source not contiguous");
   pix_step_a: assert property (state_r == ST_RUN && mem_rdy_i && !pix_last && !cls_r.negative |=> src_cur_r == AW'($past(src_cur_r) + (bpp16_r ? 2 : 1)))
      else $error("pixel step wrong for colour depth");
   expand_pos_a: assert property (wr && idx == IDX_ROP |=> expand_bit_o == $past(wb_dat_i[2:0]))
      else $error("expansion start bit not taken");
   decode_pat_a: assert property (op_r == OP_FILL_PAT_TR |=> op_class_o.pattern && op_class_o.transparent)
      else $error("pattern fill decode wrong");
   done_c: cover property (state_r == ST_DONE);
   step_c: cover property (state_r == ST_STEP && !src_lin_r);
   refused_c: cover property (refused);
   irq_c: cover property (irq_o);
endmodule

/* File: verif/bec_mem_model.sv */
`timescale 1ns/1ps
module bec_mem_model (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // pacing: 0 accepts every cycle, 1 stalls at random
   input wire logic slow_i,
   // pixel address accept
   output logic mem_rdy_o
);
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_rdy_o <= 1'b0;
      end else begin
         mem_rdy_o <= slow_i ? 1'(($urandom & 32'h3) == 32'h0) : 1'b1;
      end
   end
endmodule

/* File: verif/bec_top_tb.sv */
`timescale 1ns/1ps
module bec_top_tb;
   import bec_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, push = 1'b0, pop = 1'b0, pv = 1'b0, slow = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic [20:0] src_s = 21'h0, dst_s = 21'h0, sa, da;
   logic [9:0] npix = 10'h3, nlin = 10'h2;
   bec_pix_type pix = '0;
   logic ack, rdy, rv, busy, bpp, av, irq;
   logic [15:0] rpix;
   bec_class_type cls;
   logic [2:0] xb;
   logic [20:0] sq[$], dq[$];
   int error_cnt = 0, num_checks = 0, cyc_cnt = 0, st = 1;
   bit ng = 1'b0;
   always #5 core_clk_i = ~core_clk_i;
   bec_mem_model mem_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
      .mem_rdy_o(rdy));
   bec_top dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .src_start_i(src_s), .dst_start_i(dst_s), .line_pixels_i(npix),
      .line_count_i(nlin), .mem_rdy_i(rdy), .fifo_push_i(push), .fifo_pop_i(pop),
      .pix_valid_i(pv), .pix_i(pix), .rop_pix_o(rpix), .rop_valid_o(rv), .busy_o(busy),
      .op_class_o(cls), .bpp16_o(bpp), .expand_bit_o(xb), .addr_valid_o(av),
      .src_addr_o(sa), .dst_addr_o(da), .irq_o(irq));
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
      @(posedge core_clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      do @(posedge core_clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic fpulse(input logic p);
      @(posedge core_clk_i);
      push <= p;
      pop <= !p;
      @(posedge core_clk_i);
      push <= 1'b0;
      pop <= 1'b0;
   endtask
   function automatic logic [31:0] flags(input int lv);
      return {25'h0, lv >= 1, lv >= 7, lv >= 15, 4'h0};
   endfunction
   // sum of the four minterms that the code enables
   function automatic logic [15:0] rop_exp(input logic [3:0] c, input logic [15:0] s, d);
      return ({16{c[3]}} & s & d) | ({16{c[2]}} & s & ~d) | ({16{c[1]}} & ~s & d)
         | ({16{c[0]}} & ~s & ~d);
   endfunction
   function automatic logic [7:0] cls_exp(input int c);
      return {c > 12, c == 1, c inside {2, 3, 5, 10, 11}, c == 3, c inside {4, 5, 7, 9, 11},
         c inside {6, 7}, c inside {8, 9, 10, 11}, c == 12};
   endfunction
   // rectangles step lines by the offset of 16, linear regions keep counting pixels
   // a negative move walks the same distances downward
   function automatic logic [20:0] ea(input logic [20:0] b, input bit lin, ng, input int l, p, st);
      logic [20:0] o;
      o = lin ? 21'((l * 3 + p) * st) : 21'(l * 16 + p * st);
      return ng ? b - o : b + o;
   endfunction
   always @(negedge core_clk_i) begin
      if (av === 1'b1) begin
         sq.push_back(sa);
         dq.push_back(da);
      end
   end
   always @(posedge core_clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      void'($urandom(32'h707B));
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wb(1'b0, IDX_CTRL + 10'(i), 8'h00);
         chk("reset value", 32'h0, rdat);
      end
      wb(1'b1, 10'h1FF, 8'hA5);
      wb(1'b0, 10'h1FF, 8'h00);
      chk("unmapped", 32'h0, rdat);
      wb(1'b1, IDX_FMT, 8'h01);
      wb(1'b0, IDX_FMT, 8'h00);
      chk("format reg", 32'h1, rdat);
      chk("bpp16", 32'h1, 32'(bpp));
      $display("test registers done");
      wb(1'b1, IDX_IRQ_MASK, 8'h02);
      for (int lv = 1; lv <= 17; lv++) begin
         fpulse(1'b1);
         wb(1'b0, IDX_CTRL, 8'h00);
         chk("fifo flags up", flags(lv), rdat & 32'h70);
         chk("full irq", 32'(lv >= 15), 32'(irq));
      end
      wb(1'b1, IDX_IRQ_STAT, 8'h02);
      @(posedge core_clk_i);
      #1;
      chk("irq cleared", 32'h0, 32'(irq));
      for (int lv = 15; lv >= -1; lv--) begin
         fpulse(1'b0);
         wb(1'b0, IDX_CTRL, 8'h00);
         chk("fifo flags down", flags(lv), rdat & 32'h70);
      end
      $display("test fifo done");
      for (int k = 0; k < 32; k++) begin
         wb(1'b1, IDX_ROP, 8'(k % 16));
         wb(1'b1, IDX_OP, k < 16 ? 8'h00 : 8'h06);
         @(posedge core_clk_i);
         pv <= 1'b1;
         pix <= {16'($urandom), 16'($urandom), 16'($urandom)};
         @(posedge core_clk_i);
         pv <= 1'b0;
         #1;
         chk("rop pix", rop_exp(4'(k), k < 16 ? pix.src : pix.pat, pix.dst), rpix);
         chk("rop valid", 32'h1, 32'(rv));
         chk("expand bit", 32'(k % 8), 32'(xb));
      end
      for (int c = 0; c < 16; c++) begin
         wb(1'b1, IDX_OP, 8'(c));
         @(posedge core_clk_i);
         #1;
         chk("op class", 32'(cls_exp(c)), 32'(cls));
      end
      $display("test datapath done");
      wb(1'b1, IDX_IRQ_MASK, 8'h05);
      wb(1'b1, IDX_OFS_LO, 8'h10);
      wb(1'b1, IDX_OFS_HI, 8'h00);
      for (int r = 0; r < 3; r++) begin
         sq = {};
         dq = {};
         st = r % 2 + 1;
         ng = (r == 2);
         wb(1'b1, IDX_OP, ng ? 8'h03 : 8'h06); // width 3 suits both depths
         wb(1'b1, IDX_FMT, 8'(r % 2));
         slow <= r[0];
         src_s <= 21'($urandom) & 21'h0FFFFF;
         dst_s <= 21'($urandom) & 21'h0FFFFF;
         wb(1'b1, IDX_CTRL, r[0] ? 8'h81 : 8'h82);
         wb(1'b0, IDX_CTRL, 8'h00);
         chk("busy", r[0] ? 32'h81 : 32'h82, rdat & 32'h83);
         for (int t = 0; t < 300 && busy !== 1'b0; t++) @(posedge core_clk_i);
         wb(1'b0, IDX_CTRL, 8'h00);
         chk("idle", 32'h0, rdat & 32'h80);
         chk("addr count", 32'd6, 32'(sq.size()));
         for (int i = 0; i < 6 && i < sq.size(); i++) begin
            chk("src addr", 32'(ea(src_s, r[0], ng, i / 3, i % 3, st)), 32'(sq[i]));
            chk("dst addr", 32'(ea(dst_s, !r[0], ng, i / 3, i % 3, st)), 32'(dq[i]));
         end
         wb(1'b0, IDX_IRQ_STAT, 8'h00);
         chk("done status", 32'h1, rdat);
         chk("done irq", 32'h1, 32'(irq));
         wb(1'b1, IDX_IRQ_STAT, 8'h07);
      end
      wb(1'b1, IDX_OP, 8'h0D);
      wb(1'b1, IDX_CTRL, 8'h80);
      wb(1'b0, IDX_IRQ_STAT, 8'h00);
      chk("refused", 32'h4, rdat);
      chk("refused busy", 32'h0, 32'(busy));
      $display("test walk done");
      results();
   end
endmodule
